// ---- tb/flash_array_model.sv ----
// flash cell array model driven by the control block
`default_nettype none
module flash_array_model (
    input  wire logic        clk_i,
    input  wire logic        pgm_i,
    input  wire logic        erase_i,
    input  wire logic        mass_i,
    input  wire logic        strobe_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  data_i,
    input  wire logic [15:0] peek_addr_i,
    output logic [7:0]       peek_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    // ==========================================
    // cells start erased
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hFF;
        end
    end
    // erase or program on each strobe
    always @(posedge clk_i) begin
        if (strobe_i && erase_i && mass_i) begin
            for (int i = 0; i < 65536; i++) begin
                mem[i] = 8'hFF;
            end
        end else if (strobe_i && erase_i) begin
            for (int i = 0; i < 512; i++) begin
                mem[{addr_i[15:9], 9'h000} + i] = 8'hFF;
            end
        end else if (strobe_i && pgm_i) begin
            mem[addr_i] = mem[addr_i] & data_i;
        end
    end
    assign peek_data_o = mem[peek_addr_i];
endmodule
`default_nettype wire

// ---- tb/flash_ctl_chk.sv ----
// port assertions for the flash program and erase control block
`default_nettype none
module flash_ctl_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        arr_we_i,
    input wire logic [15:0] arr_adr_i,
    input wire logic [7:0]  arr_dat_i,
    input wire logic        array_pgm_o,
    input wire logic        array_erase_o,
    input wire logic        array_mass_o,
    input wire logic        array_hv_o,
    input wire logic [15:0] array_addr_o,
    input wire logic [7:0]  array_data_o,
    input wire logic        array_strobe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // sequences and properties
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence page_erase_s;
        array_strobe_o && array_erase_o && !array_mass_o;
    endsequence
    sequence pgm_byte_s;
        array_strobe_o && array_pgm_o;
    endsequence
    sequence conflict_wr_s;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[1:0] == 2'b11;
    endsequence
    bits_interlock_a: assert property (!(array_pgm_o && array_erase_o))
        else $error("program and erase both set");
    conflict_keep_a: assert property (conflict_wr_s |=> $stable({array_pgm_o, array_erase_o}))
        else $error("conflicting write changed mode bits");
    hv_cause_a: assert property ($rose(array_hv_o) |-> array_pgm_o || array_erase_o)
        else $error("high voltage without mode bit");
    page_align_a: assert property (page_erase_s |-> array_addr_o[8:0] == 9'h000)
        else $error("erase page not aligned");
    vector_keep_a: assert property (page_erase_s |-> array_addr_o[15:9] != 7'h7F)
        else $error("page erase hit vector page");
    erase_start_a: assert property (array_strobe_o && array_erase_o |-> $rose(array_hv_o))
        else $error("erase start not at high voltage");
    pgm_latch_a: assert property (pgm_byte_s |-> $past(arr_we_i) && array_addr_o == $past(arr_adr_i)
        && array_data_o == $past(arr_dat_i))
        else $error("programmed byte not from last write");
    pgm_bounds_a: assert property (pgm_byte_s |-> array_hv_o && array_addr_o < 16'hFFCF)
        else $error("program outside allowed space");
endmodule
bind flash_op_control_top flash_ctl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .arr_we_i(arr_we_i), .arr_adr_i(arr_adr_i), .arr_dat_i(arr_dat_i),
    .array_pgm_o(array_pgm_o), .array_erase_o(array_erase_o), .array_mass_o(array_mass_o),
    .array_hv_o(array_hv_o), .array_addr_o(array_addr_o), .array_data_o(array_data_o),
    .array_strobe_o(array_strobe_o));
`default_nettype wire

// ---- tb/flash_op_control_top_bench.sv ----
// self-checking bench for the flash program and erase control block
`default_nettype none
module flash_op_control_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, cyc, stb, we, arr_we, ack, program_select, ers, mass, hv, strobe;
    logic [7:0]  adr, arr_dat, adata, peek_d;
    logic [3:0]  sel;
    logic [15:0] arr_adr, aaddr, peek_a;
    logic [31:0] wdat, rdat;
    int          errors, checks;
    flash_op_control_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .arr_we_i(arr_we),
        .arr_adr_i(arr_adr), .arr_dat_i(arr_dat), .array_pgm_o(program_select), .array_erase_o(ers), .array_mass_o(mass),
        .array_hv_o(hv), .array_addr_o(aaddr), .array_data_o(adata), .array_strobe_o(strobe));
    flash_array_model u_model (.clk_i(clk_i), .pgm_i(program_select), .erase_i(ers), .mass_i(mass), .strobe_i(strobe),
        .addr_i(aaddr), .data_i(adata), .peek_addr_i(peek_a), .peek_data_o(peek_d));
    // ==========================================
    // tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        check($sformatf("register %h", a), e, q & m);
    endtask
    task automatic aw(input logic [15:0] a, input logic [7:0] d);
        arr_we <= 1'b1; // array writes come from the bench, not from array code
        arr_adr <= a;
        arr_dat <= d;
        @(posedge clk_i);
        arr_we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic pk(input logic [15:0] a, input logic [7:0] e);
        peek_a <= a;
        @(posedge clk_i);
        check($sformatf("array byte %h", a), {24'h00_0000, e}, {24'h00_0000, peek_d});
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================
    // clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        errors++;
        complete_run();
    end
    // ==========================================
    // tests
    initial begin
        {rst_i, cyc, stb, we, arr_we, adr, arr_dat, arr_adr, wdat, peek_a} = '0;
        rst_i = 1'b1;
        sel = 4'hF;
        errors = 0;
        checks = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0; // no reset while high voltage is on
        @(posedge clk_i);
        // reset values and unmapped space
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0010);
        rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        // write with byte lane 0 off is dropped
        sel <= 4'hE;
        wr(8'h04, 8'h55);
        sel <= 4'hF;
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
        // high voltage without any sequence
        wr(8'h00, 8'h08);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(8'h08, 32'h0000_0001, 32'h0000_0001);
        wr(8'h08, 8'h01);
        // conflicting mode writes
        wr(8'h00, 8'h03);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(8'h00, 8'h02);
        wr(8'h00, 8'h01);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0002);
        wr(8'h00, 8'h0A);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0002);
        rd(8'h08, 32'h0000_0001, 32'h0000_0001);
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h00);
        // row program with an out-of-row write
        wr(8'h04, 8'hFF);
        wr(8'h00, 8'h01);
        aw(16'h13C8, 8'h00);
        wr(8'h00, 8'h09);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0009);
        aw(16'h13C1, 8'hA5);
        aw(16'h13FF, 8'h3C);
        aw(16'h1400, 8'h00);
        wr(8'h00, 8'h08);
        wr(8'h00, 8'h00);
        pk(16'h13C1, 8'hA5);
        pk(16'h13FF, 8'h3C);
        pk(16'h1400, 8'hFF);
        // page erase chosen by the dummy write
        wr(8'h00, 8'h02);
        aw(16'h13F0, 8'h55);
        rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_13F0);
        rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0042);
        wr(8'h00, 8'h0A);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_000A);
        wr(8'h00, 8'h08);
        wr(8'h00, 8'h00);
        pk(16'h13C1, 8'hFF);
        // protected range from 1200 upwards
        wr(8'h04, 8'h12);
        wr(8'h00, 8'h02);
        aw(16'h1300, 8'h00);
        wr(8'h00, 8'h0A);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0002);
        rd(8'h08, 32'h0000_0001, 32'h0000_0001);
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h00);
        // below the protected range programming works
        wr(8'h00, 8'h01);
        aw(16'h11C0, 8'h00);
        wr(8'h00, 8'h09);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0009);
        aw(16'h11C0, 8'h5A);
        wr(8'h00, 8'h08);
        wr(8'h00, 8'h00);
        pk(16'h11C0, 8'h5A);
        // mass erase refused while protected
        wr(8'h00, 8'h06);
        aw(16'h0900, 8'h00);
        wr(8'h00, 8'h0E);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0006);
        rd(8'h08, 32'h0000_0001, 32'h0000_0001);
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h00);
        // vector page never page erased
        wr(8'h04, 8'hFF);
        wr(8'h00, 8'h02);
        aw(16'hFFD0, 8'h00);
        wr(8'h00, 8'h0A);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0002);
        rd(8'h08, 32'h0000_0001, 32'h0000_0001);
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h00);
        // mass erase with protection off
        wr(8'h00, 8'h06);
        aw(16'h0900, 8'h00);
        wr(8'h00, 8'h0E);
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_000E);
        wr(8'h00, 8'h0C);
        wr(8'h00, 8'h00);
        pk(16'h11C0, 8'hFF);
        complete_run();
    end
endmodule
`default_nettype wire

// ---- verilog/flash_addr_window.sv ----
// address window decode: array range, row match and page base
`include "flash_ctl_map.svh"
`default_nettype none
module flash_addr_window (
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] latched_i,
    output logic             in_array_o,
    output logic             same_row_o,
    output logic [15:0]      page_base_o
);
    // user array plus option byte and vectors are writable targets
    assign in_array_o  = ((addr_i >= `FC_ARRAY_BASE) && (addr_i <= `FC_ARRAY_END))
                         || (addr_i >= `FC_OPTION_ADDR);
    // rows are 64 bytes on 0x00/0x40/0x80/0xC0 boundaries
    assign same_row_o  = (addr_i[15:6] == latched_i[15:6]);
    // pages are 512 bytes on 512-byte boundaries
    assign page_base_o = {latched_i[15:9], 9'h000};
endmodule
`default_nettype wire

// ---- verilog/flash_ctl_map.svh ----
// register offsets, field positions, reset values and address constants of the flash control block
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH

// ==========================================
// register word indices (byte address = 4 x index)
`define FC_IDX_CONTROL   3'h0
`define FC_IDX_PROTECT   3'h1
`define FC_IDX_STATUS    3'h2
`define FC_IDX_LATCHED   3'h3

// ==========================================
// control register fields
`define FC_BIT_PGM       0
`define FC_BIT_ERASE     1
`define FC_BIT_MASS      2
`define FC_BIT_HV        3
`define FC_CTRL_RESET    8'h00

// ==========================================
// status register fields and protect register reset value
`define FC_BIT_REFUSED   0
`define FC_BIT_LATCHED   1
`define FC_STATE_LSB     4
`define FC_PROTECT_RESET 8'h00

// ==========================================
// array geometry and protect register codes
`define FC_ARRAY_BASE    16'h0860
`define FC_ARRAY_END     16'hFBFF
`define FC_OPTION_ADDR   16'hFFCF
`define FC_VECTOR_PAGE   7'h7F
`define FC_PAGE_LOW      9'h1FF
`define FC_NO_PROTECT    8'hFF
`define FC_TOP_PROTECT   6'h3F

`endif

// ---- verilog/flash_ctl_pkg.sv ----
// types shared by the flash control block
`default_nettype none
package flash_ctl_pkg;
    // sequence states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_READY = 4'b0100,
        ST_HIGH  = 4'b1000
    } seq_state_e;
endpackage
`default_nettype wire

// ---- verilog/flash_op_control_top.sv ----
// flash program and erase sequencer with its wishbone register file
`include "flash_ctl_map.svh"
`default_nettype none

module flash_op_control_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // processor writes into the flash space
    input  wire logic        arr_we_i,
    input  wire logic [15:0] arr_adr_i,
    input  wire logic [7:0]  arr_dat_i,
    // controls toward the flash array
    output logic             array_pgm_o,
    output logic             array_erase_o,
    output logic             array_mass_o,
    output logic             array_hv_o,
    output logic [15:0]      array_addr_o,
    output logic [7:0]       array_data_o,
    output logic             array_strobe_o
);

    // ==========================================
    // declarations
    flash_ctl_pkg::seq_state_e state;
    flash_ctl_pkg::seq_state_e next_state;

    logic        ctrl_pgm;
    logic        ctrl_erase;
    logic        ctrl_mass;
    logic        ctrl_hv;
    logic [7:0]  protect_start_register;
    logic        hv_refused;
    logic [15:0] latched_addr;

    logic        bus_req;
    logic        bus_wr;
    logic [2:0]  idx;
    logic [7:0]  wd;
    logic        wr_ctrl;
    logic        wr_protect;
    logic        wr_status;
    logic        mode_conflict;
    logic        hv_allowed;
    logic        hv_accept;
    logic        hv_reject;
    logic        addr_refused;
    logic        in_array;
    logic        same_row;
    logic [15:0] page_base;
    logic [31:0] next_rdata;
    logic        next_pgm;
    logic        next_erase;
    logic        next_mass;
    logic        bus_rd;
    logic        mapped;
    logic        erase_go;
    logic        pgm_byte;

    // ==========================================
    // bus decode
    assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr     = bus_req && wb_we_i && wb_sel_i[0];
    assign bus_rd     = bus_req && !wb_we_i;
    assign idx        = wb_adr_i[4:2];
    assign mapped     = (wb_adr_i[7:5] == 3'h0);
    assign wd         = wb_dat_i[7:0];
    assign wr_ctrl    = bus_wr && mapped && (idx == `FC_IDX_CONTROL);
    assign wr_protect = bus_wr && mapped && (idx == `FC_IDX_PROTECT);
    assign wr_status  = bus_wr && mapped && (idx == `FC_IDX_STATUS);

    // ==========================================
    // helpers
    // live address while armed, so the dummy write is judged before it latches
    flash_addr_window u_window (
        .addr_i      (arr_adr_i),
        .latched_i   (state == flash_ctl_pkg::ST_ARMED ? arr_adr_i : latched_addr),
        .in_array_o  (in_array),
        .same_row_o  (same_row),
        .page_base_o (page_base)
    );

    flash_protect_check u_protect (
        .addr_i    (latched_addr),
        .protect_i (protect_start_register),
        .erase_i   (ctrl_erase),
        .mass_i    (next_mass),
        .refused_o (addr_refused)
    );

    // ==========================================
    // control write qualification
    // setting both, or one while the other holds, changes neither
    assign mode_conflict = (wd[`FC_BIT_PGM] && wd[`FC_BIT_ERASE])
                           || (wd[`FC_BIT_PGM] && ctrl_erase)
                           || (wd[`FC_BIT_ERASE] && ctrl_pgm);

    // mode bits as they stand after this edge
    assign next_pgm   = (wr_ctrl && !mode_conflict) ? wd[`FC_BIT_PGM] : ctrl_pgm;
    assign next_erase = (wr_ctrl && !mode_conflict) ? wd[`FC_BIT_ERASE] : ctrl_erase;
    assign next_mass  = wr_ctrl ? wd[`FC_BIT_MASS] : ctrl_mass;

    // high voltage only with the armed mode bit kept and the target latched
    assign hv_allowed = (state == flash_ctl_pkg::ST_READY)
                        && ((ctrl_pgm && next_pgm) || (ctrl_erase && next_erase))
                        && !addr_refused;
    assign hv_accept  = wr_ctrl && wd[`FC_BIT_HV] && !ctrl_hv && hv_allowed;
    assign hv_reject  = wr_ctrl && wd[`FC_BIT_HV] && !ctrl_hv && !hv_allowed;

    // ==========================================
    // program and erase bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_pgm   <= 1'(`FC_CTRL_RESET >> `FC_BIT_PGM);
            ctrl_erase <= 1'b0;
        end else if (wr_ctrl && !mode_conflict) begin
            ctrl_pgm   <= wd[`FC_BIT_PGM];
            ctrl_erase <= wd[`FC_BIT_ERASE];
        end
    end

    // mass-select bit, chooses erase scope
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_mass <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_mass <= wd[`FC_BIT_MASS];
        end
    end

    // high-voltage enable, set only when allowed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_hv <= 1'b0;
        end else if (wr_ctrl) begin
            // a write with the bit clear always drops it
            if (!wd[`FC_BIT_HV]) begin
                ctrl_hv <= 1'b0;
            end else if (hv_accept) begin
                ctrl_hv <= 1'b1;
            end
        end
    end

    // protect start register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            protect_start_register <= `FC_PROTECT_RESET;
        end else if (wr_protect) begin
            protect_start_register <= wd;
        end
    end

    // sticky refusal flag, write one clears, a new refusal wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_refused <= 1'b0;
        end else if (hv_reject) begin
            hv_refused <= 1'b1;
        end else if (wr_status && wd[`FC_BIT_REFUSED]) begin
            hv_refused <= 1'b0;
        end
    end

    // ==========================================
    // sequence state
    always_comb begin
        next_state = state;
        case (state)
            // idle: no mode bit set
            flash_ctl_pkg::ST_IDLE: begin
                if (ctrl_pgm || ctrl_erase) begin
                    next_state = flash_ctl_pkg::ST_ARMED;
                end
            end
            // armed: waiting for the dummy array write
            flash_ctl_pkg::ST_ARMED: begin
                if (!ctrl_pgm && !ctrl_erase) begin
                    next_state = flash_ctl_pkg::ST_IDLE;
                end else if (arr_we_i && in_array) begin
                    next_state = flash_ctl_pkg::ST_READY;
                end
            end
            // ready: target latched, high voltage may start
            flash_ctl_pkg::ST_READY: begin
                if (!ctrl_pgm && !ctrl_erase) begin
                    next_state = flash_ctl_pkg::ST_IDLE;
                end else if (hv_accept) begin
                    next_state = flash_ctl_pkg::ST_HIGH;
                end
            end
            flash_ctl_pkg::ST_HIGH: begin
                // leave only once high voltage is dropped
                if (!ctrl_hv) begin
                    next_state = (ctrl_pgm || ctrl_erase) ? flash_ctl_pkg::ST_ARMED
                                                          : flash_ctl_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = flash_ctl_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= flash_ctl_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================
    // target address capture from the dummy write, data ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_addr <= 16'h0000;
        end else if ((state == flash_ctl_pkg::ST_ARMED) && arr_we_i && in_array
                     && (ctrl_pgm || ctrl_erase)) begin
            latched_addr <= arr_adr_i;
        end
    end

    // ==========================================
    // array start conditions
    // erase begins when high voltage is accepted in erase mode
    assign erase_go = hv_accept && ctrl_erase;
    // row bytes under high voltage; option byte and vectors never
    assign pgm_byte = (state == flash_ctl_pkg::ST_HIGH) && ctrl_pgm && ctrl_hv
                      && arr_we_i && in_array && same_row
                      && (arr_adr_i < `FC_OPTION_ADDR);

    // ==========================================
    // array side: address, data and strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            array_addr_o   <= 16'h0000;
            array_data_o   <= 8'hFF;
            array_strobe_o <= 1'b0;
        end else begin
            array_strobe_o <= 1'b0;
            if (erase_go) begin
                // mass erase covers the array from its base, else one page
                array_addr_o   <= next_mass ? `FC_ARRAY_BASE : page_base;
                array_data_o   <= 8'hFF;
                array_strobe_o <= 1'b1;
            end else if (pgm_byte) begin
                // latch each byte of the row; zero bits get programmed
                array_addr_o   <= arr_adr_i;
                array_data_o   <= arr_dat_i;
                array_strobe_o <= 1'b1;
            end
        end
    end

    // mode lines follow the control register flops
    assign array_pgm_o   = ctrl_pgm;
    assign array_erase_o = ctrl_erase;
    assign array_mass_o  = ctrl_mass;
    assign array_hv_o    = ctrl_hv;

    // ==========================================
    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (mapped) begin
            case (idx)
                `FC_IDX_CONTROL: begin
                    next_rdata[`FC_BIT_PGM]   = ctrl_pgm;
                    next_rdata[`FC_BIT_ERASE] = ctrl_erase;
                    next_rdata[`FC_BIT_MASS]  = ctrl_mass;
                    next_rdata[`FC_BIT_HV]    = ctrl_hv;
                end
                `FC_IDX_PROTECT: begin
                    next_rdata[7:0] = protect_start_register;
                end
                `FC_IDX_STATUS: begin
                    next_rdata[`FC_BIT_REFUSED] = hv_refused;
                    next_rdata[`FC_BIT_LATCHED] = (state == flash_ctl_pkg::ST_READY)
                                                  || (state == flash_ctl_pkg::ST_HIGH);
                    next_rdata[`FC_STATE_LSB +: 4] = state;
                end
                `FC_IDX_LATCHED: begin
                    next_rdata[15:0] = latched_addr;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================
    // wishbone answer, one cycle after the request; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            // reads capture the mux, writes keep the last read data
            if (bus_rd) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

endmodule
`default_nettype wire

// ---- verilog/flash_protect_check.sv ----
// decides whether high voltage is refused for the latched target
`include "flash_ctl_map.svh"
`default_nettype none
module flash_protect_check (
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  protect_i,
    input  wire logic        erase_i,
    input  wire logic        mass_i,
    output logic             refused_o
);
    logic        block_on;
    logic [15:0] start;
    logic [15:0] page_end;

    // start address from protect bits 7..1, low nine bits zero; the option byte address when bits 7..2 are all set
    assign block_on = (protect_i != `FC_NO_PROTECT);
    assign start    = (protect_i[7:2] == `FC_TOP_PROTECT) ? `FC_OPTION_ADDR
                                                         : {protect_i[7:1], 9'h000};
    assign page_end = {addr_i[15:9], `FC_PAGE_LOW};

    // protected range runs from start to the top of memory
    always_comb begin
        if (erase_i && mass_i) begin
            refused_o = block_on;
        end else if (erase_i) begin
            // vector page never erased by a page erase
            refused_o = (addr_i[15:9] == `FC_VECTOR_PAGE) || (block_on && (page_end >= start));
        end else begin
            // option byte and vectors always protected
            refused_o = (addr_i >= `FC_OPTION_ADDR) || (block_on && (addr_i >= start));
        end
    end
endmodule
`default_nettype wire
